// ===== rtl/bsc_pkg.sv
// shared constants, encodings and state types of the boundary-scan test logic
// Contract
// [R01] instruction register is three bits, loaded least significant bit first
// [R02] code 000 places the boundary cell chain between TDI and TDO
// [R03] that code captures pin levels in Capture-DR and shifts them in Shift-DR
// [R04] that code drives output pins from the pattern transferred in Update-DR
// [R05] code 010 passes pin data to and from core unchanged while sampling
// [R06] code 010 lets a pattern preload into cell latches without driving pins
// [R07] code 001 places the identification register between TDI and TDO
// [R08] code 111 passes TDI to TDO with exactly one test clock delay
// [R09] code 011 holds pins at the latched pattern, bypass bit in serial path
// [R10] high-impedance instruction floats every output; resolved here to code 100
// [R11] identification register is 32 bits, shifted out least significant bit first
// [R12] identification fields: bit0 one, maker 1..11, part 12..27, version 28..31
// [R13] bypass register is one bit forming a short TDI-to-TDO path
// [R14] each two-way pin owns two cells, one input and one output
// [R15] input cells only observe pin levels and drive nothing
// [R16] output cells observe the pin and drive it from their latch under test
// [R17] test access controller is a 16-state machine steered by TMS on TCK
// [R18] code 101 and every unassigned code act as bypass
package bsc_pkg;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE = 3'h2;
  localparam logic [IR_W-1:0] IR_CLAMP = 3'h3;
  localparam logic [IR_W-1:0] IR_HIGHZ = 3'h4;
  localparam logic [IR_W-1:0] IR_FACTORY = 3'h5;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1; // fixed pattern loaded in Capture-IR

  // ****************************************
  // identification register layout
  // ****************************************
  localparam int ID_W = 32;
  localparam int ID_MFR_W = 11;
  localparam int ID_PART_W = 16;
  localparam int ID_VER_W = 4;
  localparam logic ID_MARK = 1'h1;

  // ****************************************
  // sizes
  // ****************************************
  localparam int FIFO_DEPTH = 8;
  localparam int CELLS_PER_PIN = 2;

  // ****************************************
  // state and mode types
  // ****************************************
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } bsc_tap_state_t;

  typedef enum logic [1:0] {SEL_CHAIN, SEL_IDENT, SEL_BYPASS} bsc_dr_sel_t;

  typedef enum logic [1:0] {PIN_CORE, PIN_DRIVE, PIN_HIGHZ} bsc_pin_mode_t;

endpackage

// ===== rtl/bsc_fifo.sv
// single-clock word FIFO with valid/ready on both sides
module bsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = bsc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  // pointers wrap by overflow, so depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("bsc_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("bsc_fifo: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem[rd_ptr];

  // occupancy
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers, count and registered full/empty flags
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready_out <= (next_count != (AW + 1)'(DEPTH));
      out_valid_out <= (next_count != '0);
    end
  end

  AST_FIFO_FULL_REFUSES: assert property (@(posedge clk_in) disable iff (srst_in)
    (count == (AW + 1)'(DEPTH)) |-> !in_ready_out)
    else $error("fifo accepts a word while full");
  AST_FIFO_EMPTY_NO_VALID: assert property (@(posedge clk_in) disable iff (srst_in)
    (count == '0) |-> !out_valid_out)
    else $error("fifo offers a word while empty");
  COV_FIFO_FILLS: cover property (@(posedge clk_in) disable iff (srst_in)
    count == (AW + 1)'(DEPTH));

endmodule

// ===== rtl/bsc_top.sv
// boundary-scan test access logic: controller, instruction, data registers and pin control
module bsc_top #(
  parameter int N_PINS = 4,
  parameter int FIFO_DEPTH = bsc_pkg::FIFO_DEPTH,
  parameter logic [10:0] ID_MFR = 11'h001,  // arbitrary value
  parameter logic [15:0] ID_PART = 16'h0001, // arbitrary value
  parameter logic [3:0] ID_VER = 4'h0        // arbitrary value
) (
  // system clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // test access link
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // core side words toward the pins
  input wire logic core_valid_in,
  output logic core_ready_out,
  input wire logic [N_PINS-1:0] core_data_in,
  input wire logic [N_PINS-1:0] core_oe_in,
  // pin levels toward the core
  output logic [N_PINS-1:0] core_pin_out,
  // two-way pins
  input wire logic [N_PINS-1:0] pin_in,
  output logic [N_PINS-1:0] pin_out_out,
  output logic [N_PINS-1:0] pin_oe_out
);

  localparam int CHAIN_W = bsc_pkg::CELLS_PER_PIN * N_PINS;
  localparam int HS_W = 2 + N_PINS;
  localparam logic [bsc_pkg::ID_W-1:0] ID_VALUE = {ID_VER, ID_PART, ID_MFR, bsc_pkg::ID_MARK}; // [R12]

  if (N_PINS < 1) begin : g_bad_pins
    $error("bsc_top: N_PINS must be at least 1");
  end
  if (bsc_pkg::ID_MFR_W + bsc_pkg::ID_PART_W + bsc_pkg::ID_VER_W + 1 != bsc_pkg::ID_W) begin : g_bad_id
    $error("bsc_top: identification fields do not fill the register");
  end

  // ****************************************
  // test clock domain
  // ****************************************
  logic trst_s1;
  logic trst;
  bsc_pkg::bsc_tap_state_t state;
  bsc_pkg::bsc_tap_state_t next_state;
  logic [bsc_pkg::IR_W-1:0] instruction_shift_register;
  logic [bsc_pkg::IR_W-1:0] ir_active;
  bsc_pkg::bsc_dr_sel_t dr_sel;
  bsc_pkg::bsc_pin_mode_t tck_mode;
  logic [CHAIN_W-1:0] boundary_cell_chain;
  logic [bsc_pkg::ID_W-1:0] device_identification_register;
  logic single_bit_bypass_register;
  logic [N_PINS-1:0] upd_latch;
  logic [CHAIN_W-1:0] obs_raw;
  logic [CHAIN_W-1:0] obs_s1;
  logic [CHAIN_W-1:0] obs_s2;
  logic [CHAIN_W-1:0] obs_s3;
  logic [CHAIN_W-1:0] obs_stable;
  logic dr_out;
  logic [N_PINS-1:0] out_cells;

  // reset brought into the test clock domain; it takes effect only on edges of tck
  always_ff @(posedge tck_in) begin
    trst_s1 <= srst_in;
    trst <= trst_s1;
  end

  // controller transitions on tms
  always_comb begin
    unique case (state)
      bsc_pkg::TAP_RESET: next_state = tms_in ? bsc_pkg::TAP_RESET : bsc_pkg::TAP_IDLE;
      bsc_pkg::TAP_IDLE: next_state = tms_in ? bsc_pkg::TAP_SEL_DR : bsc_pkg::TAP_IDLE;
      bsc_pkg::TAP_SEL_DR: next_state = tms_in ? bsc_pkg::TAP_SEL_IR : bsc_pkg::TAP_CAP_DR;
      bsc_pkg::TAP_CAP_DR: next_state = tms_in ? bsc_pkg::TAP_EXIT1_DR : bsc_pkg::TAP_SHIFT_DR;
      bsc_pkg::TAP_SHIFT_DR: next_state = tms_in ? bsc_pkg::TAP_EXIT1_DR : bsc_pkg::TAP_SHIFT_DR;
      bsc_pkg::TAP_EXIT1_DR: next_state = tms_in ? bsc_pkg::TAP_UPD_DR : bsc_pkg::TAP_PAUSE_DR;
      bsc_pkg::TAP_PAUSE_DR: next_state = tms_in ? bsc_pkg::TAP_EXIT2_DR : bsc_pkg::TAP_PAUSE_DR;
      bsc_pkg::TAP_EXIT2_DR: next_state = tms_in ? bsc_pkg::TAP_UPD_DR : bsc_pkg::TAP_SHIFT_DR;
      bsc_pkg::TAP_UPD_DR: next_state = tms_in ? bsc_pkg::TAP_SEL_DR : bsc_pkg::TAP_IDLE;
      bsc_pkg::TAP_SEL_IR: next_state = tms_in ? bsc_pkg::TAP_RESET : bsc_pkg::TAP_CAP_IR;
      bsc_pkg::TAP_CAP_IR: next_state = tms_in ? bsc_pkg::TAP_EXIT1_IR : bsc_pkg::TAP_SHIFT_IR;
      bsc_pkg::TAP_SHIFT_IR: next_state = tms_in ? bsc_pkg::TAP_EXIT1_IR : bsc_pkg::TAP_SHIFT_IR;
      bsc_pkg::TAP_EXIT1_IR: next_state = tms_in ? bsc_pkg::TAP_UPD_IR : bsc_pkg::TAP_PAUSE_IR;
      bsc_pkg::TAP_PAUSE_IR: next_state = tms_in ? bsc_pkg::TAP_EXIT2_IR : bsc_pkg::TAP_PAUSE_IR;
      bsc_pkg::TAP_EXIT2_IR: next_state = tms_in ? bsc_pkg::TAP_UPD_IR : bsc_pkg::TAP_SHIFT_IR;
      bsc_pkg::TAP_UPD_IR: next_state = tms_in ? bsc_pkg::TAP_SEL_DR : bsc_pkg::TAP_IDLE;
    endcase
  end

  // controller state register
  always_ff @(posedge tck_in) begin
    if (trst) begin
      state <= bsc_pkg::TAP_RESET;
    end else begin
      state <= next_state; // [R17]
    end
  end

  // instruction shift stage, lsb leaves first so tdi enters at the top
  always_ff @(posedge tck_in) begin
    if (trst) begin
      instruction_shift_register <= bsc_pkg::IR_CAPTURE_VAL;
    end else if (state == bsc_pkg::TAP_CAP_IR) begin
      instruction_shift_register <= bsc_pkg::IR_CAPTURE_VAL;
    end else if (state == bsc_pkg::TAP_SHIFT_IR) begin
      instruction_shift_register <= {tdi_in, instruction_shift_register[bsc_pkg::IR_W-1:1]}; // [R01]
    end
  end

  // active instruction; identification is selected after reset
  always_ff @(posedge tck_in) begin
    if (trst || state == bsc_pkg::TAP_RESET) begin
      ir_active <= bsc_pkg::IR_IDCODE;
    end else if (state == bsc_pkg::TAP_UPD_IR) begin
      ir_active <= instruction_shift_register; // [R01]
    end
  end

  // decode: data register in the serial path and pin ownership
  always_comb begin
    dr_sel = bsc_pkg::SEL_BYPASS; // [R18]
    tck_mode = bsc_pkg::PIN_CORE; // [R05]
    unique case (ir_active)
      bsc_pkg::IR_EXTEST: begin
        dr_sel = bsc_pkg::SEL_CHAIN; // [R02]
        tck_mode = bsc_pkg::PIN_DRIVE; // [R04]
      end
      bsc_pkg::IR_SAMPLE: dr_sel = bsc_pkg::SEL_CHAIN; // [R05]
      bsc_pkg::IR_IDCODE: dr_sel = bsc_pkg::SEL_IDENT; // [R07]
      bsc_pkg::IR_CLAMP: tck_mode = bsc_pkg::PIN_DRIVE; // [R09]
      bsc_pkg::IR_HIGHZ: tck_mode = bsc_pkg::PIN_HIGHZ; // [R10]
      default: dr_sel = bsc_pkg::SEL_BYPASS; // [R08] [R18]
    endcase
  end

  // observed levels: even cell is the pin's input side, odd cell its driven side
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      obs_raw[2*i] = pin_in[i]; // [R14]
      obs_raw[2*i+1] = pin_out_out[i]; // [R14] [R16]
      out_cells[i] = boundary_cell_chain[2*i+1];
    end
  end

  // three-stage capture of asynchronous levels; a bit moves once stages two and three agree
  always_ff @(posedge tck_in) begin
    obs_s1 <= obs_raw;
    obs_s2 <= obs_s1;
    obs_s3 <= obs_s2;
  end

  always_ff @(posedge tck_in) begin
    if (trst) begin
      obs_stable <= '0;
    end else begin
      obs_stable <= (obs_s3 & ~(obs_s2 ^ obs_s3)) | (obs_stable & (obs_s2 ^ obs_s3));
    end
  end

  // boundary cell chain: capture snapshot, then shift toward tdo
  always_ff @(posedge tck_in) begin
    if (trst) begin
      boundary_cell_chain <= '0;
    end else if (dr_sel == bsc_pkg::SEL_CHAIN) begin
      if (state == bsc_pkg::TAP_CAP_DR) begin
        boundary_cell_chain <= obs_stable; // [R03] [R05] [R15]
      end else if (state == bsc_pkg::TAP_SHIFT_DR) begin
        boundary_cell_chain <= {tdi_in, boundary_cell_chain[CHAIN_W-1:1]}; // [R03]
      end
    end
  end

  // only output cells own a latch; input cells never reach the pins
  always_ff @(posedge tck_in) begin
    if (trst) begin
      upd_latch <= '0;
    end else if (state == bsc_pkg::TAP_UPD_DR && dr_sel == bsc_pkg::SEL_CHAIN) begin
      upd_latch <= out_cells; // [R04] [R06] [R15] [R16]
    end
  end

  // identification register, constant loaded on capture
  always_ff @(posedge tck_in) begin
    if (trst) begin
      device_identification_register <= ID_VALUE;
    end else if (dr_sel == bsc_pkg::SEL_IDENT) begin
      if (state == bsc_pkg::TAP_CAP_DR) begin
        device_identification_register <= ID_VALUE; // [R12]
      end else if (state == bsc_pkg::TAP_SHIFT_DR) begin
        device_identification_register <= {tdi_in, device_identification_register[bsc_pkg::ID_W-1:1]}; // [R11]
      end
    end
  end

  // one-bit bypass stage
  always_ff @(posedge tck_in) begin
    if (trst) begin
      single_bit_bypass_register <= 1'b0;
    end else if (dr_sel == bsc_pkg::SEL_BYPASS) begin
      if (state == bsc_pkg::TAP_CAP_DR) begin
        single_bit_bypass_register <= 1'b0;
      end else if (state == bsc_pkg::TAP_SHIFT_DR) begin
        single_bit_bypass_register <= tdi_in; // [R08] [R13]
      end
    end
  end

  // serial output select
  always_comb begin
    unique case (dr_sel)
      bsc_pkg::SEL_CHAIN: dr_out = boundary_cell_chain[0]; // [R02]
      bsc_pkg::SEL_IDENT: dr_out = device_identification_register[0]; // [R07] [R11]
      bsc_pkg::SEL_BYPASS: dr_out = single_bit_bypass_register; // [R09] [R13]
      default: dr_out = single_bit_bypass_register;
    endcase
  end

  // tdo changes on the falling edge so the far end samples a settled bit on the rising one
  always_ff @(negedge tck_in) begin
    if (trst) begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else begin
      tdo_out <= (state == bsc_pkg::TAP_SHIFT_IR) ? instruction_shift_register[0] : dr_out;
      tdo_oe_out <= (state == bsc_pkg::TAP_SHIFT_IR) || (state == bsc_pkg::TAP_SHIFT_DR);
    end
  end

  // ****************************************
  // crossing: pin mode and latch pattern
  // ****************************************
  logic [HS_W-1:0] tx_hold;
  logic hs_req;
  logic ack_s1;
  logic ack_s2;
  logic hs_ack;

  // a new word leaves only when the previous one has been acknowledged
  always_ff @(posedge tck_in) begin
    ack_s1 <= hs_ack;
    ack_s2 <= ack_s1;
  end

  always_ff @(posedge tck_in) begin
    if (trst) begin
      tx_hold <= {bsc_pkg::PIN_CORE, {N_PINS{1'b0}}};
      hs_req <= 1'b0;
    end else if (hs_req == ack_s2 && tx_hold != {tck_mode, upd_latch}) begin
      tx_hold <= {tck_mode, upd_latch};
      hs_req <= ~hs_req;
    end
  end

  // ****************************************
  // system clock domain
  // ****************************************
  logic req_s1;
  logic req_s2;
  logic req_s3;
  bsc_pkg::bsc_pin_mode_t rx_mode;
  logic [N_PINS-1:0] rx_pattern;
  logic [N_PINS-1:0] pin_s1;
  logic [N_PINS-1:0] pin_s2;
  logic [N_PINS-1:0] pin_s3;
  logic fifo_valid;
  logic [2*N_PINS-1:0] fifo_word;
  logic [N_PINS-1:0] core_word_data;
  logic [N_PINS-1:0] core_word_oe;
  logic fifo_pop_ok;

  // request toggle through three stages; tx_hold is steady while it is taken
  always_ff @(posedge mclk_in) begin
    req_s1 <= hs_req;
    req_s2 <= req_s1;
    req_s3 <= req_s2;
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rx_mode <= bsc_pkg::PIN_CORE;
      rx_pattern <= '0;
      hs_ack <= 1'b0;
    end else begin
      if (req_s2 != req_s3) begin
        rx_mode <= bsc_pkg::bsc_pin_mode_t'(tx_hold[HS_W-1:N_PINS]);
        rx_pattern <= tx_hold[N_PINS-1:0];
      end
      hs_ack <= req_s3;
    end
  end

  // pin levels toward the core, same agreement filter as the test side
  always_ff @(posedge mclk_in) begin
    pin_s1 <= pin_in;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      core_pin_out <= '0;
    end else begin
      core_pin_out <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (core_pin_out & (pin_s2 ^ pin_s3)); // [R05]
    end
  end

  // core words queue while test logic owns the pins, back-pressuring the core
  assign fifo_pop_ok = (rx_mode == bsc_pkg::PIN_CORE);

  bsc_fifo #(
    .WIDTH(2 * N_PINS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(mclk_in),
    .srst_in(srst_in),
    .in_valid_in(core_valid_in),
    .in_ready_out(core_ready_out),
    .in_data_in({core_oe_in, core_data_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop_ok),
    .out_data_out(fifo_word)
  );

  // last core word taken from the queue
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      core_word_data <= '0;
      core_word_oe <= '0;
    end else if (fifo_valid && fifo_pop_ok) begin
      core_word_data <= fifo_word[N_PINS-1:0];
      core_word_oe <= fifo_word[2*N_PINS-1:N_PINS];
    end
  end

  // pin drivers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pin_out_out <= '0;
      pin_oe_out <= '0;
    end else begin
      unique case (rx_mode)
        bsc_pkg::PIN_CORE: begin
          pin_out_out <= core_word_data; // [R05] [R06]
          pin_oe_out <= core_word_oe;
        end
        bsc_pkg::PIN_DRIVE: begin
          pin_out_out <= rx_pattern; // [R04] [R09] [R16]
          pin_oe_out <= '1;
        end
        bsc_pkg::PIN_HIGHZ: begin
          pin_out_out <= '0;
          pin_oe_out <= '0; // [R10]
        end
        default: begin
          pin_out_out <= '0;
          pin_oe_out <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_IR_LSB_FIRST: assert property (@(posedge tck_in) disable iff (trst) // [R01]
    (state == bsc_pkg::TAP_SHIFT_IR)
      |=> instruction_shift_register == {$past(tdi_in), $past(instruction_shift_register[bsc_pkg::IR_W-1:1])})
    else $error("instruction bits do not advance toward the lsb");
  AST_EXTEST_CHAIN: assert property (@(posedge tck_in) disable iff (trst) // [R02]
    (ir_active == bsc_pkg::IR_EXTEST) |-> (dr_out == boundary_cell_chain[0]))
    else $error("boundary chain not in serial path under external test");
  AST_CAPTURE_PINS: assert property (@(posedge tck_in) disable iff (trst) // [R03]
    (state == bsc_pkg::TAP_CAP_DR && dr_sel == bsc_pkg::SEL_CHAIN)
      |=> boundary_cell_chain == $past(obs_stable))
    else $error("chain did not capture observed levels");
  AST_UPDATE_LATCH: assert property (@(posedge tck_in) disable iff (trst) // [R04]
    (state == bsc_pkg::TAP_UPD_DR && dr_sel == bsc_pkg::SEL_CHAIN) |=> upd_latch == $past(out_cells))
    else $error("update did not transfer output cells");
  AST_IDCODE_LOAD: assert property (@(posedge tck_in) disable iff (trst) // [R12]
    (state == bsc_pkg::TAP_CAP_DR && ir_active == bsc_pkg::IR_IDCODE)
      |=> device_identification_register == ID_VALUE && device_identification_register[0])
    else $error("identification value not loaded on capture");
  AST_BYPASS_ONE_CYCLE: assert property (@(posedge tck_in) disable iff (trst) // [R08]
    (state == bsc_pkg::TAP_SHIFT_DR && ir_active == bsc_pkg::IR_BYPASS) |=> dr_out == $past(tdi_in))
    else $error("bypass delay is not one test clock");
  AST_FACTORY_BYPASS: assert property (@(posedge tck_in) disable iff (trst) // [R18]
    (ir_active == bsc_pkg::IR_FACTORY || ir_active == 3'h6) |-> dr_sel == bsc_pkg::SEL_BYPASS)
    else $error("unassigned code does not select bypass");
  AST_TMS_RESET: assert property (@(posedge tck_in) disable iff (trst) // [R17]
    tms_in [*5] |=> state == bsc_pkg::TAP_RESET)
    else $error("five tms highs did not reach reset");
  AST_HIGHZ_FLOAT: assert property (@(posedge mclk_in) disable iff (srst_in) // [R10]
    (rx_mode == bsc_pkg::PIN_HIGHZ) |=> pin_oe_out == '0)
    else $error("outputs driven under high impedance");
  AST_CLAMP_HOLD: assert property (@(posedge mclk_in) disable iff (srst_in) // [R09]
    (rx_mode == bsc_pkg::PIN_DRIVE && $stable(rx_mode) && $stable(rx_pattern))
      |=> $stable(pin_out_out) && pin_oe_out == '1)
    else $error("held pins changed under drive mode");

  COV_EXTEST_UPDATE: cover property (@(posedge tck_in) disable iff (trst)
    state == bsc_pkg::TAP_UPD_DR && ir_active == bsc_pkg::IR_EXTEST);
  COV_IDCODE_SHIFT: cover property (@(posedge tck_in) disable iff (trst)
    state == bsc_pkg::TAP_SHIFT_DR && ir_active == bsc_pkg::IR_IDCODE);
  COV_BYPASS_SHIFT: cover property (@(posedge tck_in) disable iff (trst)
    state == bsc_pkg::TAP_SHIFT_DR && ir_active == bsc_pkg::IR_BYPASS);
  COV_PINS_DRIVEN: cover property (@(posedge mclk_in) disable iff (srst_in)
    rx_mode == bsc_pkg::PIN_DRIVE);

endmodule

// ===== testbench/bsc_tap_host.sv
// model of the external test controller driving the serial link
module bsc_tap_host (
  // link toward the device
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // the link clock stands low between frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // one 6 ns period; tdo sampled at the rise, mid-way through its stand
  task automatic tick(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    #3 tck_out = 1'b1;
    q = tdo_in;
    #3 tck_out = 1'b0;
  endtask
  // idle data toggles so a stale bit never reads as valid
  task automatic walk(input logic m, input int n);
    logic q;
    repeat (n) tick(m, ~tdi_out, q);
  endtask
  // scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    walk(1'b1, ir ? 2 : 1);
    walk(1'b0, 2);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, din[k], q);
      dout[k] = q;
    end
    walk(1'b1, 1);
    walk(1'b0, 1);
  endtask
endmodule

// ===== testbench/tb_bsc_top.sv
// self-checking bench of the boundary-scan test logic
module tb_bsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  // id fields are arbitrary values
  localparam logic [31:0] IDV = {4'h6, 16'h5A3C, 11'h2A5, 1'b1};
  logic mclk_in, srst_in, tck, tms, tdi, tdo, tdo_oe, core_valid, core_ready;
  logic [31:0] idq;
  logic [3:0] core_data, core_oe, core_pin, pin_in, pin_o, pin_e;
  int fails = 0;
  int num_checks = 0;
  bsc_top #(.ID_MFR(11'h2A5), .ID_PART(16'h5A3C), .ID_VER(4'h6)) bsc_top_inst (
    .mclk_in(mclk_in), .srst_in(srst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .core_valid_in(core_valid), .core_ready_out(core_ready), .core_data_in(core_data),
    .core_oe_in(core_oe), .core_pin_out(core_pin), .pin_in(pin_in), .pin_out_out(pin_o), .pin_oe_out(pin_e));
  bsc_tap_host bsc_tap_host_inst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // chain image: even bits input cells, odd bits output cells
  function automatic logic [31:0] cap(input logic [3:0] p, input logic [3:0] o);
    cap = '0;
    for (int i = 0; i < 4; i++) cap[2*i +: 2] = {o[i], p[i]};
  endfunction
  // the crossing needs test clock edges, so idle in run-test while waiting; then let the observers settle
  task automatic wait_pins(input logic [3:0] o, input logic [3:0] e);
    int i;
    for (i = 0; i < 300 && !(pin_o === o && pin_e === e); i++) bsc_tap_host_inst.walk(1'b0, 1);
    chk({pin_e, pin_o}, {e, o});
    if (pin_o !== o || pin_e !== e) wrap_up();
    bsc_tap_host_inst.walk(1'b0, 4);
  endtask
  task automatic ir(input logic [2:0] c);
    logic [31:0] q;
    bsc_tap_host_inst.scan(1'b1, 3, {29'h0, c}, q);
    chk(q, 32'h1);
    chk(tdo_oe, 1'b0);
  endtask
  // caller sits on a clock edge; valid is left high for back-to-back words
  task automatic push(input logic [3:0] o, input logic [3:0] v);
    int i;
    core_valid <= 1'b1;
    core_oe <= o;
    core_data <= v;
    for (i = 0; i < 40 && core_ready !== 1'b1; i++) @(posedge mclk_in);
    if (i == 40) begin
      fails++;
      wrap_up();
    end
    @(posedge mclk_in);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_byp(input logic [2:0] c);
    logic [31:0] q;
    ir(c);
    bsc_tap_host_inst.scan(1'b0, 8, 32'hB4, q);
    chk(q, 32'h68);
    $display("bypass %h done", c);
  endtask
  task automatic t_sample();
    logic [31:0] q;
    ir(3'h2);
    @(posedge mclk_in);
    push(4'hF, 4'h5);
    core_valid <= 1'b0;
    wait_pins(4'h5, 4'hF);
    chk(core_pin, 4'h6);
    bsc_tap_host_inst.scan(1'b0, 8, cap(4'h0, 4'hC), q);
    chk(q, cap(4'h6, 4'h5));
    repeat (20) @(posedge mclk_in);
    wait_pins(4'h5, 4'hF);
    $display("sample done");
  endtask
  task automatic t_extest();
    logic [31:0] q;
    @(posedge mclk_in);
    pin_in <= 4'h9;
    ir(3'h0);
    wait_pins(4'hC, 4'hF);
    bsc_tap_host_inst.scan(1'b0, 8, cap(4'h0, 4'h3), q);
    chk(q, cap(4'h9, 4'hC));
    wait_pins(4'h3, 4'hF);
    @(posedge mclk_in);
    for (int k = 0; k < 8; k++) push(4'h0, k[3:0]);
    core_valid <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk(core_ready, 1'b0);
    $display("extest done");
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    srst_in = 1'b1;
    core_valid = 1'b0;
    core_data = 4'h0;
    core_oe = 4'h0;
    pin_in = 4'h6;
    bsc_tap_host_inst.walk(1'b1, 8);
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'b0;
    bsc_tap_host_inst.walk(1'b1, 3);
    bsc_tap_host_inst.walk(1'b0, 1);
    bsc_tap_host_inst.scan(1'b0, 32, 32'h0, idq);
    chk(idq, IDV);
    t_sample();
    t_extest();
    ir(3'h4);
    wait_pins(4'h0, 4'h0);
    t_byp(3'h3);
    wait_pins(4'h3, 4'hF);
    t_byp(3'h7);
    wait_pins(4'h7, 4'h0);
    chk(core_ready, 1'b1);
    t_byp(3'h5);
    t_byp(3'h6);
    wrap_up();
  end
endmodule
